// ===== dvrb_top.v
// eight-channel volume register bank behind the serial control port
//
// Contract
// - eight-bit per-channel code, half-decibel steps
// - 00 mutes, 01 is -127dB, FF 0dB
// - every attenuation field resets to FF
// - update bit zero stages code only
// - update bit one transfers all staged codes
// - update bit is never stored
// - master code at 0001000, same staging
// - channel registers decode at fixed addresses
// - stopped master clock restores 0dB volumes
// - write to 11111 resets all registers
// - soft reset two mclk periods or next write
// - mute decode disable is OR of copies
`timescale 1ns/10ps
`include "dvrb_map.vh"
module dvrb_top #(
  parameter MCLK_STOP_CYCLES = `DVRB_MCLK_STOP_CYCLES
) (
  input wire clk_sys_in,
  input wire rstn_in,
  input wire ctrl_clk_in,
  input wire ctrl_data_in,
  input wire ctrl_latch_in,
  input wire mclk_in,
  output wire [7:0] left_ch1_atten_out,
  output wire [7:0] right_ch1_atten_out,
  output wire [7:0] left_ch2_atten_out,
  output wire [7:0] right_ch2_atten_out,
  output wire [7:0] left_ch3_atten_out,
  output wire [7:0] right_ch3_atten_out,
  output wire [7:0] left_ch4_atten_out,
  output wire [7:0] right_ch4_atten_out,
  output wire [7:0] all_channel_atten_out,
  output reg [7:0] channel_mute_out,
  output reg [8:0] dac_control_a_out,
  output reg [8:0] interface_format_out,
  output reg [8:0] emphasis_mute_control_out,
  output reg [8:0] interface_power_control_out,
  output reg [8:0] legacy_converter_control_out,
  output reg [8:0] channel4_control_out,
  output reg mute_pin_decode_disable_out,
  output reg soft_reset_active_out,
  output wire mclk_stopped_out
);

  // --------------------------------------------------------------------
  // latch indices: eight channels, then the master code
  // --------------------------------------------------------------------
  localparam N_LATCH = 9;
  localparam [3:0] IDX_MASTER = 4'h8;
  localparam [3:0] IDX_NONE = 4'hf;

  // --------------------------------------------------------------------
  // operating notes
  // --------------------------------------------------------------------
  // timing, in system clock cycles after the latch pin rises: three to
  // synchronise the pin and find its edge, one for the registers below
  // and one more for the mute and decode flags
  // the serial clock and the latch pin each need three system cycles
  // high and low, or an edge can slip past the synchroniser
  // the master clock is seen only through its synchroniser, so it has to
  // run well below half the system clock or it reads as stopped
  // hazard: volume writes that land while the master clock counts as
  // stopped are dropped, so the host repeats them once the clock is back
  // the stop limit trades detection delay against the slowest master
  // clock that still counts as running; keep it above that clock's
  // period in system cycles

  wire word_valid;
  wire [`DVRB_WORD_W-1:0] word;
  wire mclk_rise;
  wire [6:0] addr;
  wire [8:0] data;
  wire [3:0] sel_idx;
  wire is_volume;
  wire update_all;
  wire reset_write;
  wire clear_vol;
  wire clear_ctrl;
  wire [8*N_LATCH-1:0] active_flat;
  wire master_mute;
  wire last_mclk_rise;
  wire window_word;
  reg [1:0] mclk_count;

  // --------------------------------------------------------------------
  // serial port and master clock monitor
  // --------------------------------------------------------------------
  // shifts in one word, then pulses word_valid for a single cycle
  dvrb_serial_rx #(
    .WORD_W(`DVRB_WORD_W)
  ) u_serial (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .ctrl_clk_in(ctrl_clk_in),
    .ctrl_data_in(ctrl_data_in),
    .ctrl_latch_in(ctrl_latch_in),
    .word_valid_out(word_valid),
    .word_out(word)
  );

  // finds master clock rises; the 16-bit counter leaves room for any limit up to 65535
  dvrb_mclk_monitor #(
    .STOP_CYCLES(MCLK_STOP_CYCLES),
    .CNT_W(16)
  ) u_mclk (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .mclk_in(mclk_in),
    .mclk_rise_out(mclk_rise),
    .mclk_stopped_out(mclk_stopped_out)
  );

  // --------------------------------------------------------------------
  // word decode
  // --------------------------------------------------------------------
  // split the control word into address and data fields
  assign addr = word[`DVRB_ADDR_MSB:`DVRB_ADDR_LSB];
  assign data = word[`DVRB_DATA_MSB:`DVRB_DATA_LSB];

  // map a volume register address onto its latch index
  function [3:0] latch_of;
    input [6:0] a;
    begin
      case (a)
        `DVRB_LEFT1_VOLUME: latch_of = 4'h0;
        `DVRB_RIGHT1_VOLUME: latch_of = 4'h1;
        `DVRB_LEFT2_VOLUME: latch_of = 4'h2;
        `DVRB_RIGHT2_VOLUME: latch_of = 4'h3;
        `DVRB_LEFT3_VOLUME: latch_of = 4'h4;
        `DVRB_RIGHT3_VOLUME: latch_of = 4'h5;
        `DVRB_LEFT4_VOLUME: latch_of = 4'h6;
        `DVRB_RIGHT4_VOLUME: latch_of = 4'h7;
        `DVRB_ALL_CHANNEL_VOLUME: latch_of = IDX_MASTER;
        default: latch_of = IDX_NONE;
      endcase
    end
  endfunction

  // unmapped addresses fall to no latch and the word is ignored; the
  // software reset address is decoded apart
  assign sel_idx = latch_of(addr);
  assign is_volume = word_valid && (sel_idx != IDX_NONE);
  // update bit acts only on the write that carries it, never stored
  assign update_all = is_volume && data[`DVRB_UPDATE_BIT];
  assign reset_write = word_valid && (addr == `DVRB_SOFTWARE_RESET);

  // --------------------------------------------------------------------
  // software reset window
  // --------------------------------------------------------------------
  // a word other than a reset write that arrives inside the window closes it at once
  assign window_word = soft_reset_active_out && word_valid;

  // the second synchronised master clock rise closes the window
  assign last_mclk_rise = mclk_rise &&
    (mclk_count == `DVRB_SRESET_MCLK_PERIODS - 2'h1);

  // held for two master clock rises, or ended by the next write; a
  // repeated reset write restarts the count, so the window ends at the second
  // master clock rise after the latest reset write unless a write ends it first
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      soft_reset_active_out <= 1'b0;
      mclk_count <= 2'h0;
    end else if (reset_write) begin
      soft_reset_active_out <= 1'b1;
      mclk_count <= 2'h0;
    end else if (soft_reset_active_out) begin
      if (window_word) begin
        soft_reset_active_out <= 1'b0;
      end else if (mclk_rise) begin
        if (last_mclk_rise) begin
          soft_reset_active_out <= 1'b0;
        end
        mclk_count <= mclk_count + 2'h1;
      end
    end
  end

  // registers sit at default on the reset write and while the window
  // stands; a write that ends the window is taken normally
  assign clear_ctrl = reset_write ||
    (soft_reset_active_out && !word_valid);
  // hazard: a stopped master clock wipes the staged codes as well, so an
  // update write after the clock returns cannot apply stale values
  assign clear_vol = clear_ctrl || mclk_stopped_out;

  // --------------------------------------------------------------------
  // two-stage attenuation latches
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_LATCH; g = g + 1) begin : g_latch
      reg [7:0] staged;
      reg [7:0] active;
      wire sel;
      assign sel = is_volume && (sel_idx == g);
      // staged code on every write, active code on an update write; the
      // written latch takes its new code directly, since its own staged
      // copy still holds the previous code on this edge
      always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          staged <= `DVRB_ATTEN_RST;
          active <= `DVRB_ATTEN_RST;
        end else if (clear_vol) begin
          staged <= `DVRB_ATTEN_RST;
          active <= `DVRB_ATTEN_RST;
        end else begin
          if (sel) begin
            staged <= data[`DVRB_ATTEN_MSB:0];
          end
          if (update_all) begin
            active <= sel ? data[`DVRB_ATTEN_MSB:0] : staged;
          end
        end
      end
      assign active_flat[8*g+7:8*g] = active;
    end
  endgenerate

  // active codes out, in latch order
  assign left_ch1_atten_out = active_flat[7:0];
  assign right_ch1_atten_out = active_flat[15:8];
  assign left_ch2_atten_out = active_flat[23:16];
  assign right_ch2_atten_out = active_flat[31:24];
  assign left_ch3_atten_out = active_flat[39:32];
  assign right_ch3_atten_out = active_flat[47:40];
  assign left_ch4_atten_out = active_flat[55:48];
  assign right_ch4_atten_out = active_flat[63:56];
  assign all_channel_atten_out = active_flat[71:64];

  // --------------------------------------------------------------------
  // mute flags from the active codes
  // --------------------------------------------------------------------
  // the master code at mute silences every channel at once
  assign master_mute = (active_flat[71:64] == `DVRB_ATTEN_MUTE);

  // code 00 mutes; flags lag the codes by one cycle, like every other
  // registered output derived from the register contents
  genvar m;
  generate
    for (m = 0; m < 8; m = m + 1) begin : g_mute
      always @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
          channel_mute_out[m] <= 1'b0;
        end else begin
          channel_mute_out[m] <=
            (active_flat[8*m+7:8*m] == `DVRB_ATTEN_MUTE) ||
            master_mute;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // other control registers
  // --------------------------------------------------------------------
  // plain nine-bit storage; cleared by the reset pin and the software reset only
  // these keep their contents through a master clock stop, unlike the
  // volumes; unused bits are stored as written and left to the host
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dac_control_a_out <= `DVRB_DAC_CONTROL_A_RST;
      interface_format_out <= `DVRB_INTERFACE_FORMAT_RST;
      emphasis_mute_control_out <= `DVRB_EMPHASIS_MUTE_RST;
      interface_power_control_out <= `DVRB_INTERFACE_POWER_RST;
      legacy_converter_control_out <= `DVRB_LEGACY_CONVERTER_RST;
      channel4_control_out <= `DVRB_CHANNEL4_CONTROL_RST;
    end else if (clear_ctrl) begin
      dac_control_a_out <= `DVRB_DAC_CONTROL_A_RST;
      interface_format_out <= `DVRB_INTERFACE_FORMAT_RST;
      emphasis_mute_control_out <= `DVRB_EMPHASIS_MUTE_RST;
      interface_power_control_out <= `DVRB_INTERFACE_POWER_RST;
      legacy_converter_control_out <= `DVRB_LEGACY_CONVERTER_RST;
      channel4_control_out <= `DVRB_CHANNEL4_CONTROL_RST;
    end else if (word_valid) begin
      case (addr)
        `DVRB_DAC_CONTROL_A: dac_control_a_out <= data;
        `DVRB_INTERFACE_FORMAT: interface_format_out <= data;
        `DVRB_EMPHASIS_MUTE_CONTROL: emphasis_mute_control_out <= data;
        `DVRB_INTERFACE_POWER_CONTROL: interface_power_control_out <= data;
        `DVRB_LEGACY_CONVERTER_CONTROL: legacy_converter_control_out <= data;
        `DVRB_CHANNEL4_CONTROL: channel4_control_out <= data;
        default: dac_control_a_out <= dac_control_a_out;
      endcase
    end
  end

  // either copy of the decode disable bit takes effect
  // registered so that it lines up with the mute flags
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mute_pin_decode_disable_out <= 1'b0;
    end else begin
      mute_pin_decode_disable_out <=
        legacy_converter_control_out[`DVRB_DECODE_DIS_LEGACY_BIT] |
        channel4_control_out[`DVRB_DECODE_DIS_CH4_BIT];
    end
  end

endmodule // dvrb_top

// ===== dvrb_map.vh
// register offsets, field positions, reset values and timing counts
`ifndef DVRB_MAP_VH
`define DVRB_MAP_VH

// control word layout
`define DVRB_WORD_W 16
`define DVRB_ADDR_MSB 15
`define DVRB_ADDR_LSB 9
`define DVRB_DATA_MSB 8
`define DVRB_DATA_LSB 0
`define DVRB_UPDATE_BIT 8
`define DVRB_ATTEN_MSB 7

// register addresses
`define DVRB_LEFT1_VOLUME 7'h00
`define DVRB_RIGHT1_VOLUME 7'h01
`define DVRB_DAC_CONTROL_A 7'h02
`define DVRB_INTERFACE_FORMAT 7'h03
`define DVRB_LEFT2_VOLUME 7'h04
`define DVRB_RIGHT2_VOLUME 7'h05
`define DVRB_LEFT3_VOLUME 7'h06
`define DVRB_RIGHT3_VOLUME 7'h07
`define DVRB_ALL_CHANNEL_VOLUME 7'h08
`define DVRB_EMPHASIS_MUTE_CONTROL 7'h09
`define DVRB_INTERFACE_POWER_CONTROL 7'h0a
`define DVRB_LEGACY_CONVERTER_CONTROL 7'h0c
`define DVRB_LEFT4_VOLUME 7'h0d
`define DVRB_RIGHT4_VOLUME 7'h0e
`define DVRB_CHANNEL4_CONTROL 7'h0f
`define DVRB_SOFTWARE_RESET 7'h1f

// reset values
`define DVRB_ATTEN_RST 8'hff
`define DVRB_DAC_CONTROL_A_RST 9'h120
`define DVRB_INTERFACE_FORMAT_RST 9'h000
`define DVRB_EMPHASIS_MUTE_RST 9'h000
`define DVRB_INTERFACE_POWER_RST 9'h080
`define DVRB_LEGACY_CONVERTER_RST 9'h000
`define DVRB_CHANNEL4_CONTROL_RST 9'h000

// mute pin decode disable positions
`define DVRB_DECODE_DIS_LEGACY_BIT 6
`define DVRB_DECODE_DIS_CH4_BIT 5

// attenuation code that mutes a channel
`define DVRB_ATTEN_MUTE 8'h00

// software reset length in master clock periods
`define DVRB_SRESET_MCLK_PERIODS 2'h2

// system clock cycles without a master clock edge before it counts as stopped
`define DVRB_MCLK_STOP_CYCLES 16

`endif

// ===== dvrb_serial_rx.v
// three-wire serial control receiver: shifts in one 16-bit control word
`timescale 1ns/10ps
module dvrb_serial_rx #(
  parameter WORD_W = 16
) (
  input wire clk_sys_in,
  input wire rstn_in,
  input wire ctrl_clk_in,
  input wire ctrl_data_in,
  input wire ctrl_latch_in,
  output reg word_valid_out,
  output reg [WORD_W-1:0] word_out
);

  // --------------------------------------------------------------------
  // synchronisers
  // --------------------------------------------------------------------
  reg [1:0] sclk_sync;
  reg [1:0] sdat_sync;
  reg [1:0] latch_sync;
  reg sclk_prev;
  reg latch_prev;
  reg [WORD_W-1:0] shift;

  // two flops per pin, then one more stage for edge finding
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sclk_sync <= 2'h0;
      sdat_sync <= 2'h0;
      latch_sync <= 2'h3;
      sclk_prev <= 1'b0;
      latch_prev <= 1'b1;
    end else begin
      sclk_sync <= {sclk_sync[0], ctrl_clk_in};
      sdat_sync <= {sdat_sync[0], ctrl_data_in};
      latch_sync <= {latch_sync[0], ctrl_latch_in};
      sclk_prev <= sclk_sync[1];
      latch_prev <= latch_sync[1];
    end
  end

  // --------------------------------------------------------------------
  // shift and latch
  // --------------------------------------------------------------------
  // msb first on rising clock while latch is low; word taken on latch rise
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shift <= {WORD_W{1'b0}};
      word_out <= {WORD_W{1'b0}};
      word_valid_out <= 1'b0;
    end else begin
      word_valid_out <= 1'b0;
      if (!latch_sync[1] && sclk_sync[1] && !sclk_prev) begin
        shift <= {shift[WORD_W-2:0], sdat_sync[1]};
      end
      if (latch_sync[1] && !latch_prev) begin
        word_out <= shift;
        word_valid_out <= 1'b1;
      end
    end
  end

endmodule // dvrb_serial_rx

// ===== dvrb_mclk_monitor.v
// master clock monitor: finds rising edges and detects a stopped clock
`timescale 1ns/10ps
module dvrb_mclk_monitor #(
  parameter STOP_CYCLES = 16,
  parameter CNT_W = 8
) (
  input wire clk_sys_in,
  input wire rstn_in,
  input wire mclk_in,
  output reg mclk_rise_out,
  output reg mclk_stopped_out
);

  // --------------------------------------------------------------------
  // edge detect and idle count
  // --------------------------------------------------------------------
  reg [1:0] mclk_sync;
  reg mclk_prev;
  reg [CNT_W-1:0] idle_cnt;
  wire rise;

  assign rise = mclk_sync[1] & ~mclk_prev;

  // synchronise, then count system cycles since the last edge
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mclk_sync <= 2'h0;
      mclk_prev <= 1'b0;
      idle_cnt <= {CNT_W{1'b0}};
      mclk_rise_out <= 1'b0;
      mclk_stopped_out <= 1'b1;
    end else begin
      mclk_sync <= {mclk_sync[0], mclk_in};
      mclk_prev <= mclk_sync[1];
      mclk_rise_out <= rise;
      if (rise) begin
        idle_cnt <= {CNT_W{1'b0}};
        mclk_stopped_out <= 1'b0;
      end else if (idle_cnt == STOP_CYCLES[CNT_W-1:0]) begin
        mclk_stopped_out <= 1'b1;
      end else begin
        idle_cnt <= idle_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // dvrb_mclk_monitor

// ===== dvrb_top_chk.sv
// port-level checker for the volume register bank
`timescale 1ns/10ps
module dvrb_top_chk #(
  parameter MCLK_STOP_CYCLES = 16
) (
  input wire clk_sys_in,
  input wire rstn_in,
  input wire ctrl_latch_in,
  input wire mclk_in,
  input wire [7:0] left_ch1_atten_out,
  input wire [7:0] all_channel_atten_out,
  input wire [7:0] channel_mute_out,
  input wire [8:0] dac_control_a_out,
  input wire [8:0] legacy_converter_control_out,
  input wire [8:0] channel4_control_out,
  input wire mute_pin_decode_disable_out,
  input wire soft_reset_active_out,
  input wire mclk_stopped_out
);
  reg [7:0] lat_cnt;
  reg [7:0] rise_cnt;
  // cycles since the latch pin rose and since the master clock pin rose
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lat_cnt <= 8'hff;
      rise_cnt <= 8'h00;
    end else begin
      lat_cnt <= $rose(ctrl_latch_in) ? 8'h00 :
        (lat_cnt == 8'hff ? lat_cnt : lat_cnt + 8'h01);
      rise_cnt <= $rose(mclk_in) ? 8'h00 :
        (rise_cnt == 8'hff ? rise_cnt : rise_cnt + 8'h01);
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  sequence latch_seen;
    lat_cnt <= 8'h08;
  endsequence
  sequence stop_held;
    mclk_stopped_out [*3];
  endsequence
  a_mute_flag: assert property (
    channel_mute_out[0] == ($past(left_ch1_atten_out) == 8'h00 ||
    $past(all_channel_atten_out) == 8'h00))
    else $error("mute flag does not follow the active code");
  a_decode_or: assert property (
    mute_pin_decode_disable_out == $past(legacy_converter_control_out[6] |
    channel4_control_out[5]))
    else $error("decode disable is not the or of both copies");
  a_stop_ff: assert property (stop_held |->
    left_ch1_atten_out == 8'hff && all_channel_atten_out == 8'hff)
    else $error("volumes not at full scale with clock stopped");
  a_stop_late: assert property (
    rise_cnt >= MCLK_STOP_CYCLES + 6 |-> mclk_stopped_out)
    else $error("stopped master clock not flagged");
  a_stop_early: assert property (
    $rose(mclk_stopped_out) |-> rise_cnt >= MCLK_STOP_CYCLES)
    else $error("running master clock flagged as stopped");
  a_vol_cause: assert property (!$stable(left_ch1_atten_out) |->
    latch_seen or (##[0:1] mclk_stopped_out))
    else $error("volume changed without a write or clock stop");
  a_ctrl_cause: assert property (
    !$stable(dac_control_a_out) |-> latch_seen)
    else $error("control word changed without a write");
  a_sr_defaults: assert property ($rose(soft_reset_active_out) |->
    dac_control_a_out == 9'h120 && legacy_converter_control_out == 9'h000 &&
    channel4_control_out == 9'h000 && left_ch1_atten_out == 8'hff)
    else $error("software reset left a register off default");
  a_sr_ends: assert property ($rose(soft_reset_active_out) &&
    !mclk_stopped_out |-> ##[1:40] !soft_reset_active_out)
    else $error("software reset outlasted two clock periods");
  a_sr_next_word: assert property (soft_reset_active_out &&
    $rose(ctrl_latch_in) |-> ##[1:8] !soft_reset_active_out)
    else $error("software reset not ended by the next word");
endmodule // dvrb_top_chk
bind dvrb_top dvrb_top_chk #(.MCLK_STOP_CYCLES(MCLK_STOP_CYCLES)) chk_i (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ctrl_latch_in(ctrl_latch_in),
  .mclk_in(mclk_in), .left_ch1_atten_out(left_ch1_atten_out),
  .all_channel_atten_out(all_channel_atten_out),
  .channel_mute_out(channel_mute_out), .dac_control_a_out(dac_control_a_out),
  .legacy_converter_control_out(legacy_converter_control_out),
  .channel4_control_out(channel4_control_out),
  .mute_pin_decode_disable_out(mute_pin_decode_disable_out),
  .soft_reset_active_out(soft_reset_active_out),
  .mclk_stopped_out(mclk_stopped_out));

// ===== dvrb_host_model.sv
// host model driving the three-wire serial control port
`timescale 1ns/10ps
module dvrb_host_model (
  output reg ctrl_clk_out,
  output reg ctrl_data_out,
  output reg ctrl_latch_out
);
  integer i;
  // link clock stands low and latch high outside frames
  initial begin
    ctrl_clk_out = 1'b0;
    ctrl_data_out = 1'b0;
    ctrl_latch_out = 1'b1;
  end
  // one word msb first, callers keep unused bits at zero
  task send(input [15:0] word);
    begin
      ctrl_latch_out = 1'b0;
      for (i = 15; i >= 0; i = i - 1) begin
        ctrl_data_out = word[i]; // address 15:9, data 8:0
        #400;
        ctrl_clk_out = 1'b1;
        #400;
        ctrl_clk_out = 1'b0;
      end
      #400;
      ctrl_latch_out = 1'b1;
      #400;
      ctrl_data_out = ~ctrl_data_out; // released line shows no stale bit
    end
  endtask
endmodule // dvrb_host_model

// ===== dvrb_top_tb.sv
// self-checking bench for the volume register bank
`timescale 1ns/10ps
module dvrb_top_tb;
  typedef struct packed {
    logic [15:0] word;
    logic [4:0] idx;
    logic [8:0] exp;
  } dvrb_row_t;
  reg clk_sys_in, rstn_in, mclk_in, mclk_run;
  wire ctrl_clk, ctrl_data, ctrl_latch, decode_dis, sr, stopped;
  wire [7:0] vol [0:8];
  wire [7:0] mute;
  wire [8:0] ctl [0:5];
  integer errors, compares, k, n;
  reg [8:0] rst_ctl [0:5];
  // writes in order, each with the output index and value it should give
  dvrb_row_t rows [0:19] = '{
    '{16'h0040, 5'd0, 9'h0ff}, '{16'h0320, 5'd0, 9'h040},
    '{16'h0800, 5'd2, 9'h0ff}, '{16'h11fe, 5'd8, 9'h0fe},
    '{16'h21ff, 5'd2, 9'h000}, '{16'h2000, 5'd16, 9'h004},
    '{16'h1b01, 5'd6, 9'h001}, '{16'h1daa, 5'd7, 9'h0aa},
    '{16'h0b33, 5'd3, 9'h033}, '{16'h0d44, 5'd4, 9'h044},
    '{16'h0f55, 5'd5, 9'h055}, '{16'h0222, 5'd1, 9'h020},
    '{16'h04a5, 5'd9, 9'h0a5}, '{16'h07ff, 5'd10, 9'h1ff},
    '{16'h1323, 5'd11, 9'h123}, '{16'h14f0, 5'd12, 9'h0f0},
    '{16'h1840, 5'd15, 9'h001}, '{16'h1e20, 5'd14, 9'h020},
    '{16'h1800, 5'd15, 9'h001}, '{16'h1e00, 5'd15, 9'h000}};
  dvrb_top #(.MCLK_STOP_CYCLES(16)) dvrb_top_i (.clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in), .ctrl_clk_in(ctrl_clk), .ctrl_data_in(ctrl_data),
    .ctrl_latch_in(ctrl_latch), .mclk_in(mclk_in),
    .left_ch1_atten_out(vol[0]), .right_ch1_atten_out(vol[1]),
    .left_ch2_atten_out(vol[2]), .right_ch2_atten_out(vol[3]),
    .left_ch3_atten_out(vol[4]), .right_ch3_atten_out(vol[5]),
    .left_ch4_atten_out(vol[6]), .right_ch4_atten_out(vol[7]),
    .all_channel_atten_out(vol[8]), .channel_mute_out(mute),
    .dac_control_a_out(ctl[0]), .interface_format_out(ctl[1]),
    .emphasis_mute_control_out(ctl[2]), .interface_power_control_out(ctl[3]),
    .legacy_converter_control_out(ctl[4]), .channel4_control_out(ctl[5]),
    .mute_pin_decode_disable_out(decode_dis), .soft_reset_active_out(sr),
    .mclk_stopped_out(stopped));
  dvrb_host_model host_i (.ctrl_clk_out(ctrl_clk), .ctrl_data_out(ctrl_data),
    .ctrl_latch_out(ctrl_latch));
  // system clock 100 ns
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // master clock 1 us, edges just after a system rise, low while stopped
  initial begin
    mclk_in = 1'b0;
    #55;
    forever #500 mclk_in = mclk_run ? ~mclk_in : 1'b0;
  end
  // one output selected by index, widened to nine bits
  function [8:0] obs(input integer i);
    begin
      if (i < 9) obs = {1'b0, vol[i]};
      else if (i < 15) obs = ctl[i-9];
      else if (i == 15) obs = {8'h00, decode_dis};
      else obs = {1'b0, mute};
    end
  endfunction
  task cyc(input integer c);
    begin
      repeat (c) @(posedge clk_sys_in);
      #5;
    end
  endtask
  task chk(input [8:0] got, input [8:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task close_out;
    begin
      if (errors == 0 && compares > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask
  // bounded wait on the stopped flag
  task wait_stop(input v);
    begin
      n = 0;
      while (stopped !== v && n < 200) begin
        cyc(1);
        n = n + 1;
      end
      if (n == 200) begin
        errors = errors + 1;
        close_out;
      end
    end
  endtask
  task wr(input [15:0] w);
    begin
      host_i.send(w);
      cyc(8);
    end
  endtask
  initial begin
    errors = 0;
    compares = 0;
    rstn_in = 1'b0;
    mclk_run = 1'b1;
    rst_ctl = '{9'h120, 9'h000, 9'h000, 9'h080, 9'h000, 9'h000};
    cyc(12);
    rstn_in = 1'b1;
    for (k = 0; k < 15; k = k + 1)
      chk(obs(k), k < 9 ? 9'h0ff : rst_ctl[k-9]);
    wait_stop(1'b0);
    for (k = 0; k < 20; k = k + 1) begin
      wr(rows[k].word);
      chk(obs(rows[k].idx), rows[k].exp);
    end
    // stopped master clock restores full scale
    mclk_run = 1'b0;
    wait_stop(1'b1);
    cyc(4);
    chk(obs(7), 9'h0ff);
    mclk_run = 1'b1;
    wait_stop(1'b0);
    chk(obs(0), 9'h0ff);
    wr(16'h0340);
    chk(obs(1), 9'h040);
    // software reset with the master clock running
    wr(16'h3e00);
    chk(obs(9), 9'h120);
    chk(obs(1), 9'h0ff);
    cyc(40);
    chk({8'h00, sr}, 9'h000);
    // without master clock the reset lasts until the next word
    mclk_run = 1'b0;
    wait_stop(1'b1);
    wr(16'h3e00);
    cyc(40);
    chk({8'h00, sr}, 9'h001);
    wr(16'h04a5);
    chk({8'h00, sr}, 9'h000);
    chk(obs(9), 9'h0a5);
    // master code at mute silences every channel
    mclk_run = 1'b1;
    wait_stop(1'b0);
    wr(16'h0340);
    wr(16'h1100);
    chk(obs(16), 9'h0ff);
    // reset in mid-run returns every volume, control and mute output to its default
    rstn_in = 1'b0;
    cyc(2);
    rstn_in = 1'b1;
    for (k = 0; k < 15; k = k + 1)
      chk(obs(k), k < 9 ? 9'h0ff : rst_ctl[k-9]);
    chk(obs(16), 9'h000);
    close_out;
  end
endmodule // dvrb_top_tb
